/* inc/sre_pkg.sv */
package sre_pkg;
    // register bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 8;
    localparam int IDX_W = 3;
    // register offsets
    localparam logic [7:0] RECT1_RISE_TIME_HIGH = 8'h51;
    localparam logic [7:0] RECT1_RISE_SETTING = 8'h52;
    localparam logic [7:0] RECT1_FALL_TIME_HIGH = 8'h53;
    localparam logic [7:0] RECT1_FALL_SETTING = 8'h54;
    localparam logic [7:0] RECT2_RISE_TIME_HIGH = 8'h55;
    localparam logic [7:0] RECT2_RISE_SETTING = 8'h56;
    localparam logic [7:0] RECT2_FALL_TIME_HIGH = 8'h57;
    localparam logic [7:0] RECT2_FALL_SETTING = 8'h58;
    localparam logic [7:0] REG_BASE = RECT1_RISE_TIME_HIGH;
    localparam logic [7:0] REG_LAST = RECT2_FALL_SETTING;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // setting register fields
    localparam int LSB_NIB_HI = 7;
    localparam int LSB_NIB_LO = 4;
    localparam int MOD_EN_BIT = 3;
    localparam int SIGN_BIT = 2;
    localparam int VSB_BIT = 1;
    localparam int SS_REPEAT_BIT = 1;
    localparam int SS_ON_BIT = 0;
    // edge timing
    localparam int TIME_W = 12;
    localparam int EDGES = 4;
    localparam int STEP_NS = 5;
    localparam int CLK_NS = 10;
    localparam logic [12:0] UNITS_PER_CLK = 13'(CLK_NS / STEP_NS);
    localparam logic [11:0] TIME_MAX = 12'hFFF;
    localparam logic [11:0] SS_STEP = 12'h010;
    // soft start states
    typedef enum logic [1:0] {SRE_SS_IDLE, SRE_SS_RAMP, SRE_SS_DONE} sre_ss_type;
endpackage

/* verilog/sre_regfile.sv */
`timescale 1ns/100ps
module sre_regfile
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // access port
    input wire logic wr_en_i,
    input wire logic [sre_pkg::IDX_W-1:0] idx_i,
    input wire logic [sre_pkg::DATA_W-1:0] wr_data_i,
    output logic [sre_pkg::DATA_W-1:0] rd_data_o,
    // all contents
    output logic [sre_pkg::NUM_REGS*sre_pkg::DATA_W-1:0] contents_o
);
    import sre_pkg::*;

    logic [DATA_W-1:0] mem [NUM_REGS];
    logic [DATA_W-1:0] next_rd_data;

    // registered read port
    always_comb
    begin
        next_rd_data = mem[idx_i];
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rd_data_o <= REG_RESET;
        else
            rd_data_o <= next_rd_data;
    end

    // one storage byte per register
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++)
        begin : g_byte
            always_ff @(posedge core_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    mem[g] <= REG_RESET;
                else if (wr_en_i && idx_i == IDX_W'(g))
                    mem[g] <= wr_data_i;
            end
            assign contents_o[g*DATA_W +: DATA_W] = mem[g];
        end
    endgenerate
endmodule // sre_regfile

/* verilog/sre_edge_timing.sv */
`timescale 1ns/100ps
module sre_edge_timing
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [sre_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [sre_pkg::DATA_W-1:0] reg_wr_data_i,
    output logic [sre_pkg::DATA_W-1:0] reg_rd_data_o,
    output logic reg_rd_valid_o,
    // control loop
    input wire logic period_start_i,
    input wire logic [sre_pkg::TIME_W-1:0] loop_mod_i,
    input wire logic signed [sre_pkg::TIME_W-1:0] vsb_adjust_i,
    input wire logic rect_enable_i,
    // drives
    output logic rectifier_drive_one_o,
    output logic rectifier_drive_two_o,
    output logic softstart_busy_o
);
    import sre_pkg::*;

    // address decode
    logic hit;
    logic [7:0] offs;
    logic [IDX_W-1:0] idx;
    logic [NUM_REGS*DATA_W-1:0] contents;
    logic [DATA_W-1:0] mem_rd;
    logic rd_pend;
    logic rd_hit_pend;
    logic next_rd_pend;
    logic next_rd_hit_pend;
    logic [DATA_W-1:0] next_rd_data;
    logic next_rd_valid;

    always_comb
    begin
        hit = (reg_addr_i >= REG_BASE) && (reg_addr_i <= REG_LAST);
        offs = reg_addr_i - REG_BASE;
        idx = offs[IDX_W-1:0];
    end

    sre_regfile u_regs
    (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .wr_en_i(reg_wr_i && hit),
        .idx_i(idx),
        .wr_data_i(reg_wr_data_i),
        .rd_data_o(mem_rd),
        .contents_o(contents)
    );

    // read answer two cycles after the request, unmapped reads give zero
    always_comb
    begin
        next_rd_pend = reg_rd_i;
        next_rd_hit_pend = reg_rd_i && hit;
        next_rd_valid = rd_pend;
        next_rd_data = rd_pend ? (rd_hit_pend ? mem_rd : UNMAPPED_READ) : reg_rd_data_o;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rd_pend <= 1'b0;
            rd_hit_pend <= 1'b0;
            reg_rd_valid_o <= 1'b0;
            reg_rd_data_o <= UNMAPPED_READ;
        end
        else
        begin
            rd_pend <= next_rd_pend;
            rd_hit_pend <= next_rd_hit_pend;
            reg_rd_valid_o <= next_rd_valid;
            reg_rd_data_o <= next_rd_data;
        end
    end

    // control bits of the setting registers
    logic [DATA_W-1:0] r1_rise_set;
    logic [DATA_W-1:0] r1_fall_set;
    logic volt_second_balance_rect;
    logic rect_softstart_repeat;
    logic rect_softstart_on;

    always_comb
    begin
        r1_rise_set = contents[(RECT1_RISE_SETTING - REG_BASE)*DATA_W +: DATA_W];
        r1_fall_set = contents[(RECT1_FALL_SETTING - REG_BASE)*DATA_W +: DATA_W];
        volt_second_balance_rect = r1_rise_set[VSB_BIT];
        rect_softstart_repeat = r1_fall_set[SS_REPEAT_BIT];
        rect_softstart_on = r1_fall_set[SS_ON_BIT];
    end

    // per-edge time: edge 0/1 rect one rise/fall, edge 2/3 rect two rise/fall
    logic [TIME_W-1:0] edge_time [EDGES];
    logic [TIME_W-1:0] edge_live [EDGES];
    logic [TIME_W-1:0] next_edge_time [EDGES];

    genvar e;
    generate
        for (e = 0; e < EDGES; e++)
        begin : g_edge
            logic [DATA_W-1:0] msb_reg;
            logic [DATA_W-1:0] set_reg;
            logic [TIME_W-1:0] base;
            logic signed [TIME_W+2:0] sum;

            always_comb
            begin
                msb_reg = contents[(2*e)*DATA_W +: DATA_W];
                set_reg = contents[(2*e+1)*DATA_W +: DATA_W];
                // 8 MSBs from timing register, 4 LSBs from setting nibble
                base = {msb_reg, set_reg[LSB_NIB_HI:LSB_NIB_LO]};
                sum = $signed({3'b000, base});
                if (set_reg[MOD_EN_BIT])
                begin
                    if (set_reg[SIGN_BIT])
                        sum = sum + $signed({3'b000, loop_mod_i});
                    else
                        sum = sum - $signed({3'b000, loop_mod_i});
                end
                if (volt_second_balance_rect && (e % 2 == 0))
                    sum = sum + (TIME_W+3)'(vsb_adjust_i);
                if (sum < 0)
                    edge_live[e] = '0;
                else if (sum > $signed({3'b000, TIME_MAX}))
                    edge_live[e] = TIME_MAX;
                else
                    edge_live[e] = sum[TIME_W-1:0];
                next_edge_time[e] = period_start_i ? edge_live[e] : edge_time[e];
            end

            always_ff @(posedge core_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    edge_time[e] <= '0;
                else
                    edge_time[e] <= next_edge_time[e];
            end
        end
    endgenerate

    // position within the period in 5 ns units, two units per clock
    logic [TIME_W:0] pos;
    logic [TIME_W:0] next_pos;

    always_comb
    begin
        if (period_start_i)
            next_pos = '0;
        else if (pos[TIME_W])
            next_pos = pos;
        else
            next_pos = pos + UNITS_PER_CLK;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            pos <= {1'b1, {TIME_W{1'b0}}};
        else
            pos <= next_pos;
    end

    // soft start: on-time limit grows by one step per period
    sre_ss_type ss_state;
    sre_ss_type next_ss_state;
    logic [TIME_W-1:0] ss_width;
    logic [TIME_W-1:0] next_ss_width;
    logic ss_once;
    logic next_ss_once;
    logic en_d;
    logic en_rise;

    always_comb
    begin
        en_rise = rect_enable_i && !en_d;
        next_ss_state = ss_state;
        next_ss_width = ss_width;
        next_ss_once = ss_once;
        case (ss_state)
            SRE_SS_IDLE:
            begin
                if (en_rise)
                begin
                    // with soft start on, ramp on first enable, or on each one when repeat is set
                    if (rect_softstart_on && (rect_softstart_repeat || !ss_once))
                    begin
                        next_ss_state = SRE_SS_RAMP;
                        next_ss_width = '0;
                        next_ss_once = 1'b1;
                    end
                    else
                        next_ss_state = SRE_SS_DONE;
                end
            end
            SRE_SS_RAMP:
            begin
                if (!rect_enable_i)
                    next_ss_state = SRE_SS_IDLE;
                else if (period_start_i)
                begin
                    if (ss_width > TIME_MAX - SS_STEP)
                    begin
                        next_ss_width = TIME_MAX;
                        next_ss_state = SRE_SS_DONE;
                    end
                    else
                        next_ss_width = ss_width + SS_STEP;
                end
            end
            SRE_SS_DONE:
            begin
                if (!rect_enable_i)
                    next_ss_state = SRE_SS_IDLE;
            end
            default:
                next_ss_state = SRE_SS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ss_state <= SRE_SS_IDLE;
            ss_width <= '0;
            ss_once <= 1'b0;
            en_d <= 1'b0;
        end
        else
        begin
            ss_state <= next_ss_state;
            ss_width <= next_ss_width;
            ss_once <= next_ss_once;
            en_d <= rect_enable_i;
        end
    end

    // drive generation, falling edge cut short during a ramp
    logic [TIME_W:0] fall_lim [2];
    logic next_drive [2];
    logic drive [2];
    logic next_busy;

    genvar d;
    generate
        for (d = 0; d < 2; d++)
        begin : g_drive
            logic [TIME_W:0] ramp_fall;

            always_comb
            begin
                ramp_fall = {1'b0, edge_time[2*d]} + {1'b0, ss_width};
                if (ss_state == SRE_SS_RAMP && ramp_fall < {1'b0, edge_time[2*d+1]})
                    fall_lim[d] = ramp_fall;
                else
                    fall_lim[d] = {1'b0, edge_time[2*d+1]};
                next_drive[d] = rect_enable_i && (ss_state != SRE_SS_IDLE) && !period_start_i
                    && (pos >= {1'b0, edge_time[2*d]}) && (pos < fall_lim[d]);
            end

            always_ff @(posedge core_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    drive[d] <= 1'b0;
                else
                    drive[d] <= next_drive[d];
            end
        end
    endgenerate

    always_comb
    begin
        next_busy = (next_ss_state == SRE_SS_RAMP);
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            softstart_busy_o <= 1'b0;
        else
            softstart_busy_o <= next_busy;
    end

    // outputs straight from flops
    assign rectifier_drive_one_o = drive[0];
    assign rectifier_drive_two_o = drive[1];
endmodule // sre_edge_timing

/* verification/sre_switch_model.sv */
`timescale 1ns/100ps
module sre_switch_model
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // gate seen by the switch
    input wire logic period_start_i,
    input wire logic gate_i,
    // on-time report
    output logic done_o,
    output logic [15:0] delay_o,
    output logic [15:0] width_o
);
    logic [15:0] age;
    logic gate_q;
    // time each conduction interval from the period start
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            age <= 16'h0000;
            gate_q <= 1'b0;
            done_o <= 1'b0;
            delay_o <= 16'h0000;
            width_o <= 16'h0000;
        end
        else
        begin
            age <= period_start_i ? 16'h0000 : age + 16'h0001;
            gate_q <= gate_i;
            done_o <= !gate_i && gate_q;
            if (gate_i && !gate_q)
            begin
                delay_o <= age;
                width_o <= 16'h0001;
            end
            else if (gate_i)
                width_o <= width_o + 16'h0001;
        end
    end
endmodule // sre_switch_model

/* verification/sre_edge_timing_sva.sv */
`timescale 1ns/100ps
module sre_edge_timing_chk
    import sre_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wr_data_i,
    input wire logic [7:0] reg_rd_data_o,
    input wire logic reg_rd_valid_o,
    // drives
    input wire logic period_start_i,
    input wire logic rect_enable_i,
    input wire logic rectifier_drive_one_o,
    input wire logic rectifier_drive_two_o,
    input wire logic softstart_busy_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic mapped;
    // address decode
    assign mapped = (reg_addr_i >= REG_BASE) && (reg_addr_i <= REG_LAST);
    a_read_answer_lat: assert property (reg_rd_i |-> ##2 reg_rd_valid_o)
        else $error("read answer late");
    a_answer_has_cause: assert property (reg_rd_valid_o |-> $past(reg_rd_i, 2))
        else $error("read answer without request");
    a_unmapped_zero: assert property (reg_rd_i && !mapped |-> ##2 reg_rd_data_o == UNMAPPED_READ)
        else $error("unmapped read not zero");
    a_rd_data_holds: assert property (!reg_rd_valid_o |-> $stable(reg_rd_data_o))
        else $error("read data moved");
    a_write_read_back: assert property (reg_rd_i && mapped && $past(reg_wr_i) &&
        reg_addr_i == $past(reg_addr_i) |-> ##2 reg_rd_data_o == $past(reg_wr_data_i, 3))
        else $error("read after write stale");
    a_drive_low_start: assert property (period_start_i |=> !rectifier_drive_one_o && !rectifier_drive_two_o)
        else $error("drive high after period start");
    a_drive_off_disabled: assert property (!rect_enable_i |=> !rectifier_drive_one_o && !rectifier_drive_two_o)
        else $error("drive high while disabled");
    a_busy_idle_off: assert property (!rect_enable_i [*2] |-> !softstart_busy_o)
        else $error("soft start busy while disabled");
endmodule // sre_edge_timing_chk
bind sre_edge_timing sre_edge_timing_chk u_chk (.core_clk_i, .rst_b_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wr_data_i, .reg_rd_data_o, .reg_rd_valid_o, .period_start_i, .rect_enable_i, .rectifier_drive_one_o,
    .rectifier_drive_two_o, .softstart_busy_o);

/* verification/test_sync_rectifier_edge_timing.sv */
`timescale 1ns/100ps
module test_sync_rectifier_edge_timing;
    import sre_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wr_data_i = 8'h00;
    logic period_start_i = 1'b0;
    logic [11:0] loop_mod_i = 12'h000;
    logic signed [11:0] vsb_adjust_i = 12'sh000;
    logic rect_enable_i = 1'b0;
    logic [7:0] reg_rd_data_o;
    logic reg_rd_valid_o, rectifier_drive_one_o, rectifier_drive_two_o, softstart_busy_o;
    logic one_done, two_done, watch = 1'b1;
    logic [15:0] one_dly, one_wid, two_dly, two_wid;
    logic [7:0] rd_q[$];
    logic [31:0] one_q[$], two_q[$];
    logic [11:0] tm[4];
    int failures = 0;
    int checks = 0;
    int m, adj;
    integer seed = 32'h586b;
    // 100 MHz clock
    always #5 core_clk_i = ~core_clk_i;
    sre_edge_timing u_dut (.core_clk_i, .rst_b_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wr_data_i,
        .reg_rd_data_o, .reg_rd_valid_o, .period_start_i, .loop_mod_i, .vsb_adjust_i, .rect_enable_i,
        .rectifier_drive_one_o, .rectifier_drive_two_o, .softstart_busy_o);
    sre_switch_model u_sw_one (.core_clk_i, .rst_b_i, .period_start_i, .gate_i(rectifier_drive_one_o),
        .done_o(one_done), .delay_o(one_dly), .width_o(one_wid));
    sre_switch_model u_sw_two (.core_clk_i, .rst_b_i, .period_start_i, .gate_i(rectifier_drive_two_o),
        .done_o(two_done), .delay_o(two_dly), .width_o(two_wid));
    task automatic close_out();
        if (failures == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tally(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
        tally("read data", {24'h0, e}, {24'h0, g});
    endtask
    task automatic chk_pulse(input string n, input logic [31:0] e, input logic [31:0] g);
        tally(n, e, g);
    endtask
    task automatic chk_flag(input logic e, input logic g);
        tally("soft start busy", {31'h0, e}, {31'h0, g});
    endtask
    // write, then read the same place on the very next cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wr_data_i = d;
        @(negedge core_clk_i);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b1;
        rd_q.push_back(d);
        @(negedge core_clk_i);
        reg_rd_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        rd_q.push_back(e);
        @(negedge core_clk_i);
        reg_rd_i = 1'b0;
    endtask
    task automatic kick();
        @(negedge core_clk_i);
        period_start_i = 1'b1;
        @(negedge core_clk_i);
        period_start_i = 1'b0;
    endtask
    // bounded wait for every noted result
    task automatic drain();
        for (int i = 0; i < 3000 && rd_q.size() + one_q.size() + two_q.size() > 0; i++)
            @(negedge core_clk_i);
        tally("pending results", 32'h0, 32'(rd_q.size() + one_q.size() + two_q.size()));
        if (failures > 0)
            close_out();
    endtask
    function automatic int eff(int t, logic [3:0] f, int a);
        int v;
        v = t + (f[3] ? (f[2] ? m : -m) : 0) + a;
        return v < 0 ? 0 : (v > 4095 ? 4095 : v);
    endfunction
    function automatic logic [31:0] pulse(int r, int f);
        return {16'((r + 1) / 2 + 1), 16'((f + 1) / 2 - (r + 1) / 2)};
    endfunction
    task automatic ss(input logic [1:0] mode, input logic e);
        @(negedge core_clk_i);
        rect_enable_i = 1'b0;
        wr(8'h54, {tm[1][3:0], 2'b00, mode});
        rect_enable_i = 1'b1;
        kick();
        repeat (3) @(negedge core_clk_i);
        chk_flag(e, softstart_busy_o);
    endtask
    // match each read result, and each drive result while watch is set, against the oldest note, sampled where outputs are settled
    always @(negedge core_clk_i)
    begin
        if (reg_rd_valid_o === 1'b1)
            chk_byte(rd_q.size() > 0 ? rd_q.pop_front() : 8'hXX, reg_rd_data_o);
        if (one_done === 1'b1 && watch)
            chk_pulse("drive one", one_q.size() > 0 ? one_q.pop_front() : 'x, {one_dly, one_wid});
        if (two_done === 1'b1 && watch)
            chk_pulse("drive two", two_q.size() > 0 ? two_q.pop_front() : 'x, {two_dly, two_wid});
    end
    // main sequence
    initial
    begin
        repeat (20) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        for (int a = 8'h50; a <= 8'h59; a++)
            rd(8'(a), 8'h00);
        rect_enable_i = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            logic [3:0] fl;
            fl = {i[0], i[1], 2'b00};
            m = $random(seed) & 15;
            adj = $signed(4'($random(seed)));
            loop_mod_i = 12'(m);
            vsb_adjust_i = 12'(adj);
            for (int e = 0; e < 4; e += 2)
            begin
                tm[e] = 12'(40 + ($random(seed) & 63));
                tm[e + 1] = 12'(tm[e] + 40 + ($random(seed) & 63));
            end
            for (int e = 0; e < 4; e++)
            begin
                wr(8'(8'h51 + 2 * e), tm[e][11:4]);
                wr(8'(8'h52 + 2 * e), {tm[e][3:0], fl[3:2], e == 0 && i[2], 1'b0});
            end
            one_q.push_back(pulse(eff(tm[0], fl, i[2] ? adj : 0), eff(tm[1], fl, 0)));
            two_q.push_back(pulse(eff(tm[2], fl, i[2] ? adj : 0), eff(tm[3], fl, 0)));
            kick();
            drain();
        end
        watch = 1'b0;
        ss(2'b00, 1'b0);
        ss(2'b11, 1'b1);
        ss(2'b11, 1'b1);
        ss(2'b01, 1'b0);
        drain();
        close_out();
    end
endmodule // test_sync_rectifier_edge_timing
